// ===== src/drrt_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the refresh and recovery timing link
// ----------------------------------------------------------------------------
package drrt_pkg;

	// Link commands, one per link clock cycle.
	typedef enum logic [3:0] {
		CMD_NOP,
		CMD_ACTIVATE,
		CMD_READ,
		CMD_WRITE,
		CMD_READ_AP,
		CMD_WRITE_AP,
		CMD_REFRESH,
		CMD_PRECHARGE_ALL,
		CMD_MODE_LOAD
	} drrt_cmd_t;

	// ------------------------------------------------------------------------
	// Clocking
	// ------------------------------------------------------------------------
	localparam int CLK_NS   = 50;                 // Controller clock period.
	localparam int CLK_PS   = 50000;              // Same period in picoseconds.
	localparam int LINK_DIV = 2;                  // Link clock divider, even.
	localparam int LINK_NS  = CLK_NS * LINK_DIV;  // Link clock period.

	// ------------------------------------------------------------------------
	// Times as printed, and link cycle counts (minimums round up)
	// ------------------------------------------------------------------------
	localparam int ROW_ACTIVE_MIN_NS     = 35;    // Plain default, no figure given.
	localparam int WRITE_RECOVERY_NS     = 15;
	localparam int WR_DLL_OFF_MIN_CK     = 4;
	localparam int WR_START_BURST_EIGHT_CK = 4;
	localparam int WR_START_CHOP_FIXED_CK  = 2;
	localparam int WRITE_LATENCY_CK      = 5;     // Plain default.
	localparam int REFRESH_CYCLE_NS      = 350;
	localparam int REFRESH_CYCLE_FAST_NS = 310;
	localparam int REFRESH_TO_PD_CK      = 1;     // Plain default.
	localparam int PD_EXIT_LOCKED_CK     = 10;    // Plain default.
	localparam int PREA_AFTER_REF_NS     = 40;
	localparam int REFI_PS               = 7812500;  // 64 ms over 8192 rows.

	localparam int RAS_CK  = (ROW_ACTIVE_MIN_NS + LINK_NS - 1) / LINK_NS;
	localparam int WR_CK   = (WRITE_RECOVERY_NS + LINK_NS - 1) / LINK_NS;
	localparam int WR_DLL_OFF_CK = (WR_CK > WR_DLL_OFF_MIN_CK) ? WR_CK : WR_DLL_OFF_MIN_CK;
	localparam int RFC_CK      = (REFRESH_CYCLE_NS + LINK_NS - 1) / LINK_NS;
	localparam int RFC_FAST_CK = (REFRESH_CYCLE_FAST_NS + LINK_NS - 1) / LINK_NS;
	localparam int PDEN_CK = (REFRESH_TO_PD_CK > PD_EXIT_LOCKED_CK) ? REFRESH_TO_PD_CK : PD_EXIT_LOCKED_CK;
	// Refresh intervals are maximums, so they round down.
	localparam int REFI_CLK     = REFI_PS / CLK_PS;
	localparam int REFI_HOT_CLK = REFI_PS / 2 / CLK_PS;

	// ------------------------------------------------------------------------
	// Option field on the link (mode load, or per-command chop)
	// ------------------------------------------------------------------------
	localparam int OPT_FIXED_CHOP   = 0;
	localparam int OPT_DLL_OFF      = 1;
	localparam int OPT_FAST_RFC     = 2;
	localparam int OPT_PER_CMD_CHOP = 0;

	// ------------------------------------------------------------------------
	// Controller register map
	// ------------------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_RUN       = 0;
	localparam int CTRL_HOT       = 1;
	localparam int CTRL_FAST_RFC  = 2;
	localparam int CTRL_DLL_OFF   = 3;
	localparam int CTRL_FIXED_CHOP = 4;
	localparam int CTRL_PDOWN     = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam int ST_PENDING = 0;
	localparam int ST_PDOWN   = 1;
	localparam int ST_DUE     = 2;
	localparam int ST_REFCNT  = 8;

endpackage : drrt_pkg

// ===== src/drrt_link_if.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Command link between controller and memory
// ----------------------------------------------------------------------------
interface drrt_link_if;
	logic       ck;       // Link clock, made by the controller.
	logic       reset_n;  // Memory reset, active low.
	logic       cke;      // Clock enable, low for power down.
	logic [3:0] cmd;      // Command code.
	logic [2:0] bank;     // Bank address.
	logic [2:0] opt;      // Mode bits or per-command chop.

	modport ctrl (output ck, reset_n, cke, cmd, bank, opt);
	modport dev  (input  ck, reset_n, cke, cmd, bank, opt);
endinterface : drrt_link_if

// ===== src/drrt_timer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Down counter that blocks a dependent action until it reaches zero
// ----------------------------------------------------------------------------
module drrt_timer #(
	parameter int W = 8
) (
	// Clock and reset
	input  logic         clk_i,
	input  logic         rstn_i,
	// Load and status
	input  logic         load_i,
	input  logic [W-1:0] value_i,
	output logic         zero_o
);
	if (W < 2) begin : g_bad_width
		$error("drrt_timer width too small");
	end

	logic [W-1:0] cnt;       // Cycles still to wait.
	logic [W-1:0] next_cnt;  // Next count.

	// Load wins over counting, and the count rests at zero.
	always_comb begin
		next_cnt = cnt;
		if (load_i) begin
			next_cnt = value_i;
		end else if (cnt != '0) begin
			next_cnt = cnt - 1'b1;
		end
	end

	// Register the count.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign zero_o = (cnt == '0);
endmodule : drrt_timer

// ===== src/drrt_device.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Memory end: auto precharge, write recovery and refresh busy tracking
// ----------------------------------------------------------------------------
module drrt_device
	import drrt_pkg::*;
(
	// Link from the controller
	drrt_link_if.dev   link,
	// Observed state
	output logic [7:0] bank_open_o,
	output logic       refresh_busy_o,
	output logic       write_recovery_o,
	output logic       auto_pre_o,
	output logic       illegal_cmd_o
);
	// ------------------------------------------------------------------------
	// Reset pin synchroniser
	// ------------------------------------------------------------------------
	logic rst_meta;  // First stage, read only by the second.
	logic rstn;      // Synchronised reset, active low.

	// The pin may change at any time relative to the link clock.
	always_ff @(posedge link.ck) begin
		rst_meta <= link.reset_n;
		rstn     <= rst_meta;
	end

	// ------------------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------------------
	drrt_cmd_t  cmd;          // Command seen, NOP while clock enable is low.
	logic [7:0] ras_ok;       // Row active minimum met, per bank.
	logic [7:0] act_load;     // Activate strobe, per bank.
	logic       wr_ok;        // Write recovery over.
	logic       wr_load;      // Start of write recovery wait.
	logic [7:0] wr_value;     // Latency, start offset and recovery.
	logic       rfc_ok;       // Refresh cycle over.
	logic       rfc_load;     // Refresh taken.
	logic [7:0] rfc_value;    // Refresh cycle in link cycles.

	assign cmd = link.cke ? drrt_cmd_t'(link.cmd) : CMD_NOP;

	for (genvar b = 0; b < 8; b++) begin : g_bank
		assign act_load[b] = (cmd == CMD_ACTIVATE) && (link.bank == 3'(b));
		drrt_timer #(.W(8)) u_ras (
			.clk_i   (link.ck),
			.rstn_i  (rstn),
			.load_i  (act_load[b]),
			.value_i (8'(RAS_CK)),
			.zero_o  (ras_ok[b])
		);
	end

	drrt_timer #(.W(8)) u_wr (
		.clk_i   (link.ck),
		.rstn_i  (rstn),
		.load_i  (wr_load),
		.value_i (wr_value),
		.zero_o  (wr_ok)
	);

	drrt_timer #(.W(8)) u_rfc (
		.clk_i   (link.ck),
		.rstn_i  (rstn),
		.load_i  (rfc_load),
		.value_i (rfc_value),
		.zero_o  (rfc_ok)
	);

	// ------------------------------------------------------------------------
	// Bank and mode state
	// ------------------------------------------------------------------------
	logic [7:0] open, next_open;        // Open rows.
	logic [7:0] ap_pend, next_ap_pend;  // Auto precharge waiting.
	logic [7:0] ap_wr, next_ap_wr;      // Waiting one came from a write.
	logic [2:0] mode, next_mode;        // Mode bits from the last load.
	logic       pre, next_pre;          // Internal precharge pulse.
	logic       bad, next_bad;          // Command refused pulse.
	logic       busy, next_busy;        // Refresh busy copy.
	logic       wrec, next_wrec;        // Write recovery copy.

	// Recovery starts four cycles after latency, two when chop is fixed.
	assign wr_value = 8'(WRITE_LATENCY_CK)
		+ (mode[OPT_FIXED_CHOP] ? 8'(WR_START_CHOP_FIXED_CK) : 8'(WR_START_BURST_EIGHT_CK))
		+ (mode[OPT_DLL_OFF] ? 8'(WR_DLL_OFF_CK) : 8'(WR_CK));
	assign rfc_value = mode[OPT_FAST_RFC] ? 8'(RFC_FAST_CK) : 8'(RFC_CK);
	assign wr_load  = (cmd == CMD_WRITE) || (cmd == CMD_WRITE_AP);
	assign rfc_load = (cmd == CMD_REFRESH) && rfc_ok && (open == 8'h00);

	// Decode commands and release deferred precharges.
	always_comb begin
		next_open    = open;
		next_ap_pend = ap_pend;
		next_ap_wr   = ap_wr;
		next_mode    = mode;
		next_pre     = 1'b0;
		next_bad     = 1'b0;
		next_busy    = ~rfc_ok;
		next_wrec    = ~wr_ok;
		// Self-timed precharge waits for row active minimum, and for recovery only after a write.
		for (int b = 0; b < 8; b++) begin
			if (ap_pend[b] && ras_ok[b] && (!ap_wr[b] || wr_ok)) begin
				next_open[b]    = 1'b0;
				next_ap_pend[b] = 1'b0;
				next_pre        = 1'b1;
			end
		end
		case (cmd)
			CMD_ACTIVATE: begin
				if (open[link.bank] || !rfc_ok) begin
					next_bad = 1'b1;
				end else begin
					next_open[link.bank] = 1'b1;
				end
			end
			CMD_READ, CMD_WRITE, CMD_READ_AP, CMD_WRITE_AP: begin
				if (!open[link.bank] || ap_pend[link.bank]) begin
					next_bad = 1'b1;
				end else if (cmd == CMD_READ_AP || cmd == CMD_WRITE_AP) begin
					next_ap_pend[link.bank] = 1'b1;
					next_ap_wr[link.bank]   = (cmd == CMD_WRITE_AP);
				end
			end
			CMD_PRECHARGE_ALL: begin
				next_open    = 8'h00;
				next_ap_pend = 8'h00;
			end
			CMD_REFRESH: begin
				// Refresh needs all banks closed and the last refresh done.
				next_bad = !rfc_load;
			end
			CMD_MODE_LOAD: begin
				next_mode = link.opt;
			end
			default: begin
				next_open = next_open;
			end
		endcase
	end

	// Register bank and mode state.
	always_ff @(posedge link.ck) begin
		if (!rstn) begin
			open    <= 8'h00;
			ap_pend <= 8'h00;
			ap_wr   <= 8'h00;
			mode    <= 3'h0;
			pre     <= 1'b0;
			bad     <= 1'b0;
			busy    <= 1'b0;
			wrec    <= 1'b0;
		end else begin
			open    <= next_open;
			ap_pend <= next_ap_pend;
			ap_wr   <= next_ap_wr;
			mode    <= next_mode;
			pre     <= next_pre;
			bad     <= next_bad;
			busy    <= next_busy;
			wrec    <= next_wrec;
		end
	end

	assign bank_open_o      = open;
	assign refresh_busy_o   = busy;
	assign write_recovery_o = wrec;
	assign auto_pre_o       = pre;
	assign illegal_cmd_o    = bad;
endmodule : drrt_device

// ===== src/drrt_ctrl.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module drrt_ctrl
	import drrt_pkg::*;
(
	// Clock and reset
	input  logic        clk_i,
	input  logic        rstn_i,
	// Register port
	input  logic [7:0]  reg_addr_i,
	input  logic [31:0] reg_wdata_i,
	input  logic        reg_wr_i,
	input  logic        reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Link to the memory
	drrt_link_if.ctrl   link
);
	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	typedef enum {ST_RESET, ST_IDLE, ST_AFTER_REF, ST_POWER_DOWN} drrt_state_t;

	drrt_state_t state, next_state;      // Sequencer state.
	logic        phase, next_phase;      // Link clock level.
	logic        tick;                   // First controller cycle of a link cycle, while the link clock is high.
	logic [5:0]  ctrl, next_ctrl;        // Control register.
	logic [7:0]  pcmd, next_pcmd;        // Pending command word.
	logic        pend, next_pend;        // Command waiting to go out.
	logic [31:0] rdata, next_rdata;      // Read data, one cycle after strobe.
	logic [7:0]  refi, next_refi;        // Controller cycles to next refresh.
	logic        due, next_due;          // Refresh owed.
	logic [7:0]  refcnt, next_refcnt;    // Refreshes issued, wraps.
	logic        rst_n, next_rst_n;      // Memory reset pin.
	logic        cke, next_cke;          // Clock enable pin.
	logic [3:0]  cmd, next_cmd;          // Command pins.
	logic [2:0]  bank, next_bank;        // Bank pins.
	logic [2:0]  opt, next_opt;          // Option pins.
	logic        issue_ref;              // Refresh goes out this tick.
	logic        rfc_ok, rfc_load;       // Refresh cycle counter.
	logic        wr_ok, wr_load;         // Write recovery counter.
	logic        pd_ok, pd_load;         // Refresh-to-powerdown counter.
	logic [7:0]  rfc_value, wr_value;    // Counter loads in controller cycles.
	logic [7:0]  refi_load;              // Interval for the present temperature.

	// ------------------------------------------------------------------------
	// Blocking counters, loaded in controller cycles
	// ------------------------------------------------------------------------
	// A refresh window at least two link cycles long leaves a NOP between refreshes.
	assign rfc_value = 8'(LINK_DIV) * ((ctrl[CTRL_FAST_RFC] ? 8'(RFC_FAST_CK) : 8'(RFC_CK))
		+ ((RFC_CK < 2) ? 8'h01 : 8'h00));
	// The controller waits out the write path the memory counts.
	assign wr_value = 8'(LINK_DIV) * (8'(WRITE_LATENCY_CK)
		+ (ctrl[CTRL_FIXED_CHOP] ? 8'(WR_START_CHOP_FIXED_CK) : 8'(WR_START_BURST_EIGHT_CK))
		+ (ctrl[CTRL_DLL_OFF] ? 8'(WR_DLL_OFF_CK) : 8'(WR_CK)));
	assign refi_load = ctrl[CTRL_HOT] ? 8'(REFI_HOT_CLK) : 8'(REFI_CLK);

	drrt_timer #(.W(8)) u_rfc (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.load_i  (rfc_load),
		.value_i (rfc_value),
		.zero_o  (rfc_ok)
	);

	drrt_timer #(.W(8)) u_wr (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.load_i  (wr_load),
		.value_i (wr_value),
		.zero_o  (wr_ok)
	);

	// Covers both the refresh delay and the locked exit delay, conservatively.
	drrt_timer #(.W(8)) u_pd (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.load_i  (pd_load),
		.value_i (8'(LINK_DIV * PDEN_CK)),
		.zero_o  (pd_ok)
	);

	// ------------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------------
	// Writes to the command word while one waits are ignored.
	always_comb begin
		next_ctrl  = ctrl;
		next_pcmd  = pcmd;
		next_rdata = 32'h0000_0000;
		if (reg_wr_i && reg_addr_i == REG_CTRL) begin
			next_ctrl = reg_wdata_i[5:0];
		end
		if (reg_wr_i && reg_addr_i == REG_CMD && !pend) begin
			next_pcmd = reg_wdata_i[7:0];
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CTRL:   next_rdata = {26'h0, ctrl};
				REG_CMD:    next_rdata = {24'h0, pcmd};
				REG_STATUS: begin
					next_rdata[ST_PENDING]         = pend;
					next_rdata[ST_PDOWN]           = (state == ST_POWER_DOWN);
					next_rdata[ST_DUE]             = due;
					next_rdata[ST_REFCNT +: 8]     = refcnt;
				end
				default:    next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Refresh interval
	// ------------------------------------------------------------------------
	// Refreshes go out at the first idle tick after they fall due with write recovery over, so nine always fit in 70.3 us.
	always_comb begin
		next_refi = refi;
		// Counting down to zero takes one cycle more than the load, so load one less.
		if (state == ST_RESET) begin
			next_refi = refi_load - 8'h01;
		end else if (refi == 8'h00) begin
			next_refi = refi_load - 8'h01;
		end else begin
			next_refi = refi - 8'h01;
		end
		// A new deadline wins over the refresh that clears the old one.
		next_due = ((refi == 8'h00) && state != ST_RESET) || (due && !issue_ref);
		next_refcnt = refcnt + (issue_ref ? 8'h01 : 8'h00);
	end

	// ------------------------------------------------------------------------
	// Command sequencer, one command per link cycle
	// ------------------------------------------------------------------------
	// Pins change as the link clock falls, so they are steady at its rise.
	assign tick = phase;
	assign issue_ref = tick && rfc_ok && wr_ok && due && state == ST_IDLE;

	always_comb begin
		next_phase = ~phase;
		next_state = state;
		next_pend  = pend;
		next_rst_n = rst_n;
		next_cke   = cke;
		next_cmd   = cmd;
		next_bank  = bank;
		next_opt   = opt;
		rfc_load   = 1'b0;
		wr_load    = 1'b0;
		pd_load    = 1'b0;
		if (reg_wr_i && reg_addr_i == REG_CMD && !pend) begin
			next_pend = 1'b1;
		end
		if (tick) begin
			next_cmd = 4'(CMD_NOP);
			case (state)
				ST_RESET: begin
					// Memory stays in reset until software starts it.
					next_rst_n = 1'b0;
					next_cke   = 1'b0;
					if (ctrl[CTRL_RUN]) begin
						next_rst_n = 1'b1;
						next_cke   = 1'b1;
						next_state = ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (issue_ref) begin
						next_cmd   = 4'(CMD_REFRESH);
						rfc_load   = 1'b1;
						pd_load    = 1'b1;
						next_state = ST_AFTER_REF;
					end else if (ctrl[CTRL_PDOWN] && pd_ok && rfc_ok && wr_ok && !due) begin
						next_cke   = 1'b0;
						next_state = ST_POWER_DOWN;
					end else if (pend && rfc_ok && (wr_ok || pcmd[3:0] != 4'(CMD_PRECHARGE_ALL))) begin
						// Software keeps its row addresses spread; nothing here checks it.
						next_cmd  = pcmd[3:0];
						next_bank = pcmd[6:4];
						next_opt  = (pcmd[3:0] == 4'(CMD_MODE_LOAD))
							? {ctrl[CTRL_FAST_RFC], ctrl[CTRL_DLL_OFF], ctrl[CTRL_FIXED_CHOP]}
							: {2'b00, pcmd[7]};
						next_pend = 1'b0;
						wr_load   = (pcmd[3:0] == 4'(CMD_WRITE)) || (pcmd[3:0] == 4'(CMD_WRITE_AP));
					end
				end
				ST_AFTER_REF: begin
					if (LINK_NS <= PREA_AFTER_REF_NS) begin
						next_state = ST_IDLE;
					end else if (rfc_ok) begin
						next_cmd   = 4'(CMD_PRECHARGE_ALL);
						next_state = ST_IDLE;
					end
				end
				ST_POWER_DOWN: begin
					if (!ctrl[CTRL_PDOWN] || due) begin
						next_cke   = 1'b1;
						next_state = ST_IDLE;
					end
				end
				default: begin
					next_state = ST_RESET;
				end
			endcase
			if (!ctrl[CTRL_RUN]) begin
				next_state = ST_RESET;
				next_rst_n = 1'b0;
				next_cke   = 1'b0;
			end
		end
	end

	// Register everything; pins hold reset low from the start.
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state  <= ST_RESET;
			phase  <= 1'b0;
			ctrl   <= CTRL_RESET;
			pcmd   <= 8'h00;
			pend   <= 1'b0;
			rdata  <= 32'h0000_0000;
			refi   <= 8'h00;
			due    <= 1'b0;
			refcnt <= 8'h00;
			rst_n  <= 1'b0;
			cke    <= 1'b0;
			cmd    <= 4'h0;
			bank   <= 3'h0;
			opt    <= 3'h0;
		end else begin
			state  <= next_state;
			phase  <= next_phase;
			ctrl   <= next_ctrl;
			pcmd   <= next_pcmd;
			pend   <= next_pend;
			rdata  <= next_rdata;
			refi   <= next_refi;
			due    <= next_due;
			refcnt <= next_refcnt;
			rst_n  <= next_rst_n;
			cke    <= next_cke;
			cmd    <= next_cmd;
			bank   <= next_bank;
			opt    <= next_opt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign reg_rdata_o  = rdata;
	assign link.ck      = phase;
	assign link.reset_n = rst_n;
	assign link.cke     = cke;
	assign link.cmd     = cmd;
	assign link.bank    = bank;
	assign link.opt     = opt;
endmodule : drrt_ctrl

// ===== sim/drrt_monitor.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Controller-side link checks
// ----------------------------------------------------------------------------
module drrt_monitor
	import drrt_pkg::*;
(
	// Link signals
	input  wire logic       ck,
	input  wire logic       reset_n,
	input  wire logic       cke,
	input  wire logic [3:0] cmd,
	input  wire logic [2:0] bank,
	input  wire logic [2:0] opt
);
	localparam int RATE_MAX = 100;  // Hot or normal interval plus worst stall.
	logic [7:0] since_ref;          // Link cycles since the last refresh, saturating.
	logic [7:0] awake_ref;          // Awake link cycles since the last refresh.
	logic [7:0] next_since_ref;
	logic [7:0] next_awake_ref;

	// Power down does not count against the refresh rate, so only awake cycles add up.
	always_comb begin
		next_since_ref = (since_ref == 8'hFF) ? since_ref : since_ref + 8'h01;
		next_awake_ref = cke ? awake_ref + 8'h01 : awake_ref;
		if (cmd == CMD_REFRESH) begin
			next_since_ref = 8'h00;
			next_awake_ref = 8'h00;
		end
	end

	// A long gap is assumed at reset so that an early power down is not blamed.
	always_ff @(posedge ck) begin
		since_ref <= reset_n ? next_since_ref : 8'hFF;
		awake_ref <= reset_n ? next_awake_ref : 8'h00;
	end

	default clocking cb @(posedge ck); endclocking
	default disable iff (!reset_n);
	sequence s_ref;
		cmd == CMD_REFRESH;
	endsequence
	sequence s_rfc_wait;
		(cmd == CMD_NOP) [*3];
	endsequence

	AST_REF_SPACING: assert property (s_ref |=> (cmd != CMD_REFRESH) [*5])
		else $error("refreshes too close");
	AST_RFC_NO_ACT: assert property (s_ref |=> (cmd != CMD_ACTIVATE) [*4])
		else $error("activate inside refresh cycle");
	AST_PREA_AFTER: assert property (s_ref |=> s_rfc_wait ##[1:8] cmd == CMD_PRECHARGE_ALL)
		else $error("no precharge all after refresh");
	AST_PD_ENTRY: assert property ($fell(cke) |-> since_ref >= PDEN_CK - 1)
		else $error("power down too soon after refresh");
	AST_REF_AWAKE: assert property (s_ref |-> cke && $past(cke))
		else $error("refresh while clock disabled");
	AST_REF_RATE: assert property (cke |-> awake_ref <= RATE_MAX)
		else $error("refresh overdue");
	AST_RESET_QUIET: assert property ($rose(reset_n) |-> (cmd == CMD_NOP) [*3])
		else $error("command too soon after reset");
	AST_REF_GAP: assert property (s_ref |=> cmd == CMD_NOP)
		else $error("refresh not followed by a gap");
	COV_PDOWN: cover property ($fell(cke));
endmodule : drrt_monitor

// ===== sim/ddr3_refresh_recovery_timing_tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Both link ends joined, driven through the register port
// ----------------------------------------------------------------------------
module ddr3_refresh_recovery_timing_tb import drrt_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rstn_i;
	logic [7:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [31:0] reg_rdata_o;
	logic [7:0]  bank_open_o;
	logic        auto_pre_o;
	logic        refresh_busy_o;
	logic        write_recovery_o;
	logic        illegal_cmd_o;
	logic        rd_q = 1'b0;  // Read strobe one cycle late: data stands now.
	logic [63:0] exp_q[$];     // Mask and expected word of each pending read.
	logic [63:0] note;
	logic [2:0]  b;
	int          fails = 0;
	int          samples_checked = 0;
	int          ref_cnt = 0;  // Refresh commands seen on the link.
	int          bad_cnt = 0;  // Commands refused by the memory.
	int          n;
	int          e_cyc;

	drrt_link_if i_drrt_link_if ();
	drrt_ctrl i_drrt_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .link(i_drrt_link_if.ctrl));
	drrt_device i_drrt_device (.link(i_drrt_link_if.dev), .bank_open_o(bank_open_o),
		.refresh_busy_o(refresh_busy_o), .write_recovery_o(write_recovery_o), .auto_pre_o(auto_pre_o),
		.illegal_cmd_o(illegal_cmd_o));
	drrt_monitor i_drrt_monitor (.ck(i_drrt_link_if.ck), .reset_n(i_drrt_link_if.reset_n),
		.cke(i_drrt_link_if.cke), .cmd(i_drrt_link_if.cmd), .bank(i_drrt_link_if.bank), .opt(i_drrt_link_if.opt));

	always #25 clk_i = ~clk_i;

	task check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task end_sim;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// One-cycle write; the next access follows after one idle cycle.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// The expected word waits in the queue until the data stand.
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back({m, e});
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask : rd

	// A command is only taken when none is pending, so leave room for a refresh.
	task op(input logic [7:0] c);
		wr(REG_CMD, {24'h000000, c});
		repeat (60) @(posedge clk_i);
	endtask : op

	always @(posedge clk_i) begin
		rd_q <= reg_rd_i;
		if (rd_q === 1'b1) begin
			note = exp_q.pop_front();
			check(reg_rdata_o & note[63:32], note[31:0]);
		end
	end

	always @(posedge i_drrt_link_if.ck) begin
		if (i_drrt_link_if.cmd === CMD_REFRESH) ref_cnt++;
		if (illegal_cmd_o === 1'b1) bad_cnt++;
	end

	initial begin
		#(50 * 20000);
		fails++;
		end_sim();
	end

	initial begin
		{rstn_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		void'($urandom(32'hFF686E4D));
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(REG_CTRL, 32'hFFFFFFFF, 32'h00000000);
		rd(REG_STATUS, 32'hFFFFFFFF, 32'h00000000);
		rd(8'h0C, 32'hFFFFFFFF, 32'h00000000);
		// Refresh count over ten normal intervals, then with the hot rate.
		for (int hot = 0; hot < 2; hot++) begin
			wr(REG_CTRL, 32'h1 | (32'(hot) << CTRL_HOT));
			n = ref_cnt;
			repeat (10 * REFI_CLK) @(posedge clk_i);
			n = ref_cnt - n;
			check({31'h0, n >= 9 * (hot + 1) && n <= 11 * (hot + 1)}, 32'h1);
		end
		// Write recovery start per burst mode: eight, fixed chop, DLL off, per-command chop.
		for (int m = 0; m < 4; m++) begin
			b = 3'($urandom_range(7));
			wr(REG_CTRL, 32'h1 | (32'(m == 1) << CTRL_FIXED_CHOP) | (32'(m == 2) << CTRL_DLL_OFF));
			op(8'(CMD_MODE_LOAD));
			// Row work starts just after a refresh, so that no refresh meets an open row.
			@(posedge i_drrt_link_if.ck iff i_drrt_link_if.cmd === CMD_REFRESH);
			repeat (2) @(posedge i_drrt_link_if.ck);
			check({31'h0, refresh_busy_o}, 32'h1);
			op({1'b0, b, 4'(CMD_ACTIVATE)});
			check({31'h0, bank_open_o[b]}, 32'h1);
			e_cyc = WRITE_LATENCY_CK + ((m == 1) ? WR_START_CHOP_FIXED_CK : WR_START_BURST_EIGHT_CK);
			e_cyc += (m == 2) ? WR_DLL_OFF_CK : WR_CK;
			wr(REG_CMD, {24'h000000, m == 3, b, 4'(CMD_WRITE_AP)});
			for (n = 0; i_drrt_link_if.cmd !== CMD_WRITE_AP && n < 100; n++) @(posedge i_drrt_link_if.ck);
			for (n = 0; auto_pre_o !== 1'b1 && n < 40; n++) @(posedge i_drrt_link_if.ck);
			check({31'h0, n >= e_cyc && n <= e_cyc + 3}, 32'h1);
			check({31'h0, write_recovery_o}, 32'h0);
			repeat (4) @(posedge clk_i);
			check({31'h0, bank_open_o[b]}, 32'h0);
		end
		// A read with self-timed precharge closes its own row before the next refresh.
		@(posedge i_drrt_link_if.ck iff i_drrt_link_if.cmd === CMD_REFRESH);
		op({1'b0, b, 4'(CMD_ACTIVATE)});
		op({1'b0, b, 4'(CMD_READ_AP)});
		check({31'h0, bank_open_o[b]}, 32'h0);
		// Power down entry and exit; entry is looked for well after a refresh.
		wr(REG_CTRL, 32'h21);
		@(posedge i_drrt_link_if.ck iff i_drrt_link_if.cmd === CMD_REFRESH);
		repeat (40) @(posedge clk_i);
		rd(REG_STATUS, 32'h2, 32'h2);
		wr(REG_CTRL, 32'h1);
		repeat (60) @(posedge clk_i);
		rd(REG_STATUS, 32'h2, 32'h0);
		repeat (4) @(posedge clk_i);
		check(32'(bad_cnt), 32'h0);
		end_sim();
	end
endmodule : ddr3_refresh_recovery_timing_tb
